//--- core/ctsi_pkg.sv
// Purpose: constants for the transmit-port status and interrupt block
// Assumes: 32-bit Avalon-MM data, byte addresses, 8-bit registers in lane 0
// Notes: register byte address is four times the register index
package ctsi_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 8;
    localparam int NUM_PORTS = 4;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_TX_PORT_STATUS = 8'h35;
    localparam logic [ADDR_W-1:0] IDX_TX_INTERRUPT_ENABLE = 8'h36;
    localparam logic [ADDR_W-1:0] IDX_TX_INTERRUPT_STATUS = 8'h37;
    localparam logic [ADDR_W-1:0] IDX_FORWARDING_CONTROL_TWO = 8'h38;
    localparam logic [ADDR_W-1:0] ADDR_TX_PORT_STATUS = 8'hd4;
    localparam logic [ADDR_W-1:0] ADDR_TX_INTERRUPT_ENABLE = 8'hd8;
    localparam logic [ADDR_W-1:0] ADDR_TX_INTERRUPT_STATUS = 8'hdc;
    localparam logic [ADDR_W-1:0] ADDR_FORWARDING_CONTROL_TWO = 8'he0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STS_PORT_NUM = 4;
    localparam int STS_SYNC = 1;
    localparam int STS_PASS = 0;
    localparam int CAUSE_RX_PORT = 4;
    localparam int CAUSE_ALIGN_ERR = 3;
    localparam int CAUSE_ALIGNED = 2;
    localparam int CAUSE_VALID_LOSS = 1;
    localparam int CAUSE_VALID_ASSERT = 0;
    localparam int CTL_SYNC_EN = 0;
    localparam int CTL_SYNC_FWD = 1;
    localparam int CTL_PASS_ALL = 2;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [REG_W-1:0] ENABLE_MASK = 8'h1f;
    localparam logic [REG_W-1:0] CTRL_MASK = 8'h07;
    localparam logic [REG_W-1:0] LATCH_MASK = 8'h0f;

endpackage : ctsi_pkg

//--- core/ctsi_status_irq.sv
// Purpose: status, enables and latched causes of one transmit port
// Assumes: all hub-side inputs come from logic on clk_i
// Notes: Avalon-MM slave, one wait cycle per access
//
// Notes on behaviour
// - status bit 4 shows selected read port
// - status bit 1 high when streams aligned
// - sync status forced 0 when sync disabled
// - bit 0 any port valid, or all
// - async: pass only while delivering, error clears
// - sync: pass means available; delivery gated by sync
// - enable bits 4..0 gate matching causes
// - cause 4 mirrors receive-port interrupt level
// - latch align error, clear on read
// - latch any forwarded port valid loss
// - latch pass assertion, clear on read
// - registers reset zero, reserved bits zero
// - mode 0 any enabled, 1 all enabled
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module ctsi_status_irq (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ctsi_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [ctsi_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [ctsi_pkg::BE_W-1:0] avs_byteenable_i,
    output logic [ctsi_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic tx_port_sel_i,
    input wire logic streams_aligned_i,
    input wire logic align_error_i,
    input wire logic [ctsi_pkg::NUM_PORTS-1:0] port_valid_i,
    input wire logic [ctsi_pkg::NUM_PORTS-1:0] port_enabled_i,
    input wire logic delivering_i,
    input wire logic tx_error_i,
    input wire logic rx_port_irq_i,
    output logic deliver_ok_o,
    output logic irq_o
);
    import ctsi_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [REG_W-1:0] enable_reg;
    logic [REG_W-1:0] ctrl_reg;
    logic [REG_W-1:0] flags_reg;
    logic [REG_W-1:0] flags_next;
    logic port_num_reg;
    logic sync_reg;
    logic sync_next;
    logic pass_reg;
    logic pass_next;
    logic [NUM_PORTS-1:0] fwd_valid_reg;
    logic [NUM_PORTS-1:0] fwd_valid;
    logic rx_irq_reg;
    logic waitrequest_reg;
    logic [DATA_W-1:0] readdata_reg;
    logic [DATA_W-1:0] readdata_next;
    logic irq_reg;
    logic deliver_reg;
    logic accept;
    logic rd_isr;
    logic wr_lane0;
    logic any_valid;
    logic all_valid;
    logic pass_raw;
    logic [REG_W-1:0] set_mask;
    logic [REG_W-1:0] clr_mask;
    logic [REG_W-1:0] status_view;
    logic [REG_W-1:0] isr_view;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    assign accept = (avs_read_i || avs_write_i) && !waitrequest_reg;
    assign rd_isr = accept && avs_read_i && (avs_address_i == ADDR_TX_INTERRUPT_STATUS);
    assign wr_lane0 = accept && avs_write_i && avs_byteenable_i[0];

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            waitrequest_reg <= 1'b1;
        end else begin
            waitrequest_reg <= !((avs_read_i || avs_write_i) && waitrequest_reg);
        end
    end

    // ------------------------------------------------------------
    // live status
    // ------------------------------------------------------------
    assign fwd_valid = port_valid_i & port_enabled_i;
    assign any_valid = |fwd_valid;
    assign all_valid = (|port_enabled_i) && (fwd_valid == port_enabled_i);
    assign pass_raw = ctrl_reg[CTL_PASS_ALL] ? all_valid : any_valid;
    assign sync_next = ctrl_reg[CTL_SYNC_EN] && streams_aligned_i;

    always_comb begin
        if (ctrl_reg[CTL_SYNC_FWD]) begin
            pass_next = pass_raw;
        end else begin
            pass_next = pass_raw && delivering_i && !tx_error_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_num_reg <= 1'b0;
            sync_reg <= 1'b0;
            pass_reg <= 1'b0;
            fwd_valid_reg <= '0;
            rx_irq_reg <= 1'b0;
            deliver_reg <= 1'b0;
        end else begin
            port_num_reg <= tx_port_sel_i;
            sync_reg <= sync_next;
            pass_reg <= pass_next;
            fwd_valid_reg <= fwd_valid;
            rx_irq_reg <= rx_port_irq_i;
            deliver_reg <= pass_next && (sync_next || !ctrl_reg[CTL_SYNC_FWD]);
        end
    end

    // ------------------------------------------------------------
    // latched causes
    // ------------------------------------------------------------
    always_comb begin
        set_mask = '0;
        set_mask[CAUSE_ALIGN_ERR] = align_error_i;
        set_mask[CAUSE_ALIGNED] = sync_next && !sync_reg;
        set_mask[CAUSE_VALID_LOSS] = |(fwd_valid_reg & ~fwd_valid);
        set_mask[CAUSE_VALID_ASSERT] = pass_next && !pass_reg;
        clr_mask = '0;
        if (rd_isr) begin
            clr_mask = readdata_reg[REG_W-1:0] & LATCH_MASK;
        end
        if (wr_lane0 && avs_address_i == ADDR_TX_INTERRUPT_STATUS) begin
            clr_mask = clr_mask | (avs_writedata_i[REG_W-1:0] & LATCH_MASK);
        end
        flags_next = ((flags_reg & ~clr_mask) | set_mask) & LATCH_MASK;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            flags_reg <= RESET_VALUE;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_reg <= RESET_VALUE;
            ctrl_reg <= RESET_VALUE;
        end else if (wr_lane0) begin
            if (avs_address_i == ADDR_TX_INTERRUPT_ENABLE) begin
                enable_reg <= avs_writedata_i[REG_W-1:0] & ENABLE_MASK;
            end
            if (avs_address_i == ADDR_FORWARDING_CONTROL_TWO) begin
                ctrl_reg <= avs_writedata_i[REG_W-1:0] & CTRL_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        status_view = '0;
        status_view[STS_PORT_NUM] = port_num_reg;
        status_view[STS_SYNC] = sync_reg;
        status_view[STS_PASS] = pass_reg;
        isr_view = flags_reg;
        isr_view[CAUSE_RX_PORT] = rx_irq_reg;
        readdata_next = '0;
        case (avs_address_i)
            ADDR_TX_PORT_STATUS: readdata_next[REG_W-1:0] = status_view;
            ADDR_TX_INTERRUPT_ENABLE: readdata_next[REG_W-1:0] = enable_reg;
            ADDR_TX_INTERRUPT_STATUS: readdata_next[REG_W-1:0] = isr_view;
            ADDR_FORWARDING_CONTROL_TWO: readdata_next[REG_W-1:0] = ctrl_reg;
            default: readdata_next = '0;
        endcase
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            readdata_reg <= '0;
        end else if (avs_read_i && waitrequest_reg) begin
            readdata_reg <= readdata_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |({rx_irq_reg, flags_reg[CAUSE_ALIGN_ERR:0]} & enable_reg[CAUSE_RX_PORT:0]);
        end
    end

    assign avs_readdata_o = readdata_reg;
    assign avs_waitrequest_o = waitrequest_reg;
    assign irq_o = irq_reg;
    assign deliver_ok_o = deliver_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    port_num_a: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> port_num_reg == $past(tx_port_sel_i))
        else $error("port number status wrong");

    sync_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !ctrl_reg[CTL_SYNC_EN] |=> !sync_reg)
        else $error("sync status set while disabled");

    sync_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_reg[CTL_SYNC_EN] && streams_aligned_i) |=> sync_reg)
        else $error("sync status missed alignment");

    pass_all_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_reg[CTL_PASS_ALL] && ctrl_reg[CTL_SYNC_FWD] && (fwd_valid != port_enabled_i)) |=> !pass_reg)
        else $error("pass set with a port missing");

    pass_async_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_reg[CTL_SYNC_FWD] && tx_error_i) |=> !pass_reg)
        else $error("pass kept through error");

    pass_any_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_reg[CTL_PASS_ALL] && ctrl_reg[CTL_SYNC_FWD] && any_valid) |=> pass_reg)
        else $error("pass missed valid port");

    deliver_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_reg[CTL_SYNC_FWD] && !sync_next) |=> !deliver_ok_o)
        else $error("delivery while unsynchronised");

    align_err_a: assert property (@(posedge clk_i) disable iff (reset_i)
        align_error_i |=> flags_reg[CAUSE_ALIGN_ERR])
        else $error("align error not latched");

    aligned_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(sync_reg) |-> flags_reg[CAUSE_ALIGNED])
        else $error("sync assertion not latched");

    valid_loss_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (|(fwd_valid_reg & ~fwd_valid)) |=> flags_reg[CAUSE_VALID_LOSS])
        else $error("valid loss not latched");

    valid_assert_a: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(pass_reg) |-> flags_reg[CAUSE_VALID_ASSERT])
        else $error("pass assertion not latched");

    read_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_isr && readdata_reg[CAUSE_VALID_ASSERT] && !set_mask[CAUSE_VALID_ASSERT])
        |=> !flags_reg[CAUSE_VALID_ASSERT])
        else $error("read did not clear cause");

    rx_mirror_a: assert property (@(posedge clk_i) disable iff (reset_i)
        rx_port_irq_i |=> rx_irq_reg ##1 (irq_o || !enable_reg[CAUSE_RX_PORT]))
        else $error("receive-port cause lost");

    irq_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ((flags_reg[CAUSE_ALIGN_ERR:0] & enable_reg[CAUSE_ALIGN_ERR:0]) == 4'h0 && !(rx_irq_reg && enable_reg[CAUSE_RX_PORT]))
        |=> !irq_o)
        else $error("interrupt without enabled cause");

    reserved_a: assert property (@(posedge clk_i) disable iff (reset_i)
        avs_readdata_o[DATA_W-1:5] == '0)
        else $error("reserved bits read non-zero");

    align_err_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_isr && readdata_reg[CAUSE_ALIGN_ERR] && !set_mask[CAUSE_ALIGN_ERR])
        |=> !flags_reg[CAUSE_ALIGN_ERR])
        else $error("read did not clear align error");

    aligned_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_isr && readdata_reg[CAUSE_ALIGNED] && !set_mask[CAUSE_ALIGNED])
        |=> !flags_reg[CAUSE_ALIGNED])
        else $error("read did not clear sync cause");

    loss_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_isr && readdata_reg[CAUSE_VALID_LOSS] && !set_mask[CAUSE_VALID_LOSS])
        |=> !flags_reg[CAUSE_VALID_LOSS])
        else $error("read did not clear valid loss");

    irq_raise_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (|({rx_irq_reg, flags_reg[CAUSE_ALIGN_ERR:0]} & enable_reg[CAUSE_RX_PORT:0])) |=> irq_o)
        else $error("enabled cause gave no interrupt");

    enable_bits_a: assert property (@(posedge clk_i) disable iff (reset_i)
        enable_reg[REG_W-1:CAUSE_RX_PORT+1] == '0)
        else $error("reserved enable bits set");

    deliver_sync_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_reg[CTL_SYNC_FWD] && sync_next && pass_next) |=> deliver_ok_o)
        else $error("delivery withheld while synchronised");

endmodule : ctsi_status_irq

//--- test/ctsi_status_irq_tb.sv
// Purpose: self-checking bench for the transmit-port status and interrupt block
// Assumes: hub inputs sampled on clk_i, bus answer timed by waitrequest
// Notes: status rows first, then refusals, interrupt causes and a mid-run reset
`timescale 1ns/100ps
module testbench;
    import ctsi_pkg::*;
    typedef struct packed {
        logic [2:0] ctl;
        logic sel;
        logic al;
        logic [3:0] vld;
        logic [3:0] ena;
        logic dlv;
        logic err;
        logic [7:0] sts;
        logic dok;
    } ctsi_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [DATA_W-1:0] wdat = '0;
    logic [BE_W-1:0] be = '0;
    logic [DATA_W-1:0] rdat;
    logic wait_o;
    logic irq;
    logic dok;
    logic sel = 1'b0, al = 1'b0, aerr = 1'b0, dlv = 1'b0, terr = 1'b0, rxirq = 1'b0;
    logic [NUM_PORTS-1:0] vld = '0, ena = '0;
    int failures = 0;
    int cmp_count = 0;
    ctsi_row_t rows [10] = '{
        '{3'h0, 1'h1, 1'h1, 4'hf, 4'hf, 1'h1, 1'h0, 8'h11, 1'h1},
        '{3'h1, 1'h0, 1'h1, 4'h1, 4'h3, 1'h1, 1'h0, 8'h03, 1'h1},
        '{3'h1, 1'h0, 1'h0, 4'h1, 4'h3, 1'h1, 1'h1, 8'h00, 1'h0},
        '{3'h1, 1'h0, 1'h1, 4'h1, 4'h3, 1'h0, 1'h0, 8'h02, 1'h0},
        '{3'h5, 1'h0, 1'h1, 4'h1, 4'h3, 1'h1, 1'h0, 8'h02, 1'h0},
        '{3'h5, 1'h1, 1'h1, 4'h3, 4'h3, 1'h1, 1'h0, 8'h13, 1'h1},
        '{3'h7, 1'h0, 1'h1, 4'h3, 4'h3, 1'h0, 1'h1, 8'h03, 1'h1},
        '{3'h6, 1'h0, 1'h1, 4'h0, 4'h0, 1'h1, 1'h0, 8'h00, 1'h0},
        '{3'h2, 1'h0, 1'h1, 4'h4, 4'h4, 1'h0, 1'h0, 8'h01, 1'h0},
        '{3'h2, 1'h0, 1'h1, 4'h4, 4'h8, 1'h0, 1'h0, 8'h00, 1'h0}};

    ctsi_status_irq dut (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .tx_port_sel_i(sel), .streams_aligned_i(al), .align_error_i(aerr), .port_valid_i(vld),
        .port_enabled_i(ena), .delivering_i(dlv), .tx_error_i(terr), .rx_port_irq_i(rxirq),
        .deliver_ok_o(dok), .irq_o(irq));

    initial forever #2 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task summarize;
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 50);
        if (wait_o !== 1'b0) begin
            failures++;
            summarize();
        end
    endtask : bus_wait

    task bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        adr <= a;
        rd <= 1'b1;
        bus_wait();
        d = rdat;
        rd <= 1'b0;
    endtask : bus_rd

    task bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [BE_W-1:0] b);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        be <= b;
        wr <= 1'b1;
        bus_wait();
        wr <= 1'b0;
    endtask : bus_wr

    task rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        bus_rd(a, d);
        chk(d, e);
    endtask : rdchk

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        ctsi_row_t r;
        logic [DATA_W-1:0] d;
        tick(10);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, dok}, 32'h0);
        reset_i <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            bus_wr(ADDR_FORWARDING_CONTROL_TWO, {29'h0, r.ctl}, 4'h1);
            {sel, al, vld, ena, dlv, terr} <= {r.sel, r.al, r.vld, r.ena, r.dlv, r.err};
            tick(3);
            chk({31'h0, dok}, {31'h0, r.dok});
            rdchk(ADDR_TX_PORT_STATUS, {24'h0, r.sts});
            chk({31'h0, irq}, 32'h0);
        end
        bus_wr(ADDR_FORWARDING_CONTROL_TWO, 32'h1, 4'h1);
        {sel, al, vld, ena, dlv, terr} <= '0;
        tick(3);
        bus_rd(ADDR_TX_INTERRUPT_STATUS, d);
        bus_wr(ADDR_TX_INTERRUPT_ENABLE, 32'hff, 4'h1);
        rdchk(ADDR_TX_INTERRUPT_ENABLE, 32'h1f);
        bus_wr(ADDR_TX_INTERRUPT_ENABLE, 32'h0, 4'h0);
        rdchk(ADDR_TX_INTERRUPT_ENABLE, 32'h1f);
        rdchk(8'hf0, 32'h0);
        bus_wr(ADDR_TX_PORT_STATUS, 32'hff, 4'h1);
        rdchk(ADDR_TX_PORT_STATUS, 32'h0);
        al <= 1'b1;
        tick(3);
        chk({31'h0, irq}, 32'h1);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h04);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h00);
        rdchk(ADDR_TX_PORT_STATUS, 32'h02);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        aerr <= 1'b1;
        tick(1);
        aerr <= 1'b0;
        bus_wr(ADDR_TX_INTERRUPT_ENABLE, 32'h17, 4'h1);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h08);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h00);
        aerr <= 1'b1;
        tick(1);
        aerr <= 1'b0;
        bus_wr(ADDR_TX_INTERRUPT_STATUS, 32'h08, 4'h1);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h00);
        bus_wr(ADDR_TX_INTERRUPT_ENABLE, 32'h1f, 4'h1);
        {vld, ena} <= {4'h2, 4'h2};
        tick(3);
        vld <= 4'h0;
        tick(3);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h02);
        {dlv, vld} <= {1'b1, 4'h2};
        tick(3);
        rdchk(ADDR_TX_PORT_STATUS, 32'h03);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h01);
        terr <= 1'b1;
        tick(3);
        rdchk(ADDR_TX_PORT_STATUS, 32'h02);
        rxirq <= 1'b1;
        tick(3);
        chk({31'h0, irq}, 32'h1);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h10);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h10);
        rxirq <= 1'b0;
        tick(3);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h00);
        chk({31'h0, irq}, 32'h0);
        {sel, al, vld, ena, dlv, terr} <= '0;
        tick(3);
        aerr <= 1'b1;
        tick(1);
        aerr <= 1'b0;
        tick(3);
        chk({31'h0, irq}, 32'h1);
        reset_i <= 1'b1;
        tick(2);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, wait_o}, 32'h1);
        reset_i <= 1'b0;
        rdchk(ADDR_TX_PORT_STATUS, 32'h0);
        rdchk(ADDR_TX_INTERRUPT_ENABLE, 32'h0);
        rdchk(ADDR_TX_INTERRUPT_STATUS, 32'h0);
        summarize();
    end
endmodule : testbench
